//--- logic/d3cpd_decoder.sv
// DDR3 command-pin decoder with bank tracking, data lanes and an APB status port.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module d3cpd_decoder #(
	parameter int BANKS = 8,
	parameter int MEM_AW = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_clk,
	input wire d3cpd_pkg::d3cpd_cmd_t cmd_pins,
	input wire d3cpd_pkg::d3cpd_pad_in_t pad_in,
	output d3cpd_pkg::d3cpd_pad_out_t pad_out
);
	import d3cpd_pkg::*;

	typedef enum {LK_IDLE, LK_READ, LK_WRITE} d3cpd_state_t;

	// The bank map and memory index are sized for eight banks.
	if (BANKS != 8 || MEM_AW != 8) begin : g_check
		$error("d3cpd_decoder supports only BANKS=8 and MEM_AW=8");
	end

	logic enable;
	logic req_tgl;
	logic ak1, ak2, ak3;
	d3cpd_snap_t snap_ref;
	logic lr1, lr2, lr3, link_rst;
	logic en1, en2, en3, link_en;
	logic rq1, rq2, rq3, ack_tgl;
	d3cpd_snap_t snap_link;
	d3cpd_cmd_t cmd_q;
	d3cpd_kind_t kind;
	logic [BANKS-1:0] bank_open;
	logic [3:0] close_cnt [BANKS];
	logic [13:0] open_row [BANKS];
	d3cpd_state_t state;
	logic [2:0] burst_bank;
	logic [2:0] burst_col;
	logic [3:0] burst_len;
	logic [3:0] beat;
	logic burst_ap;
	logic burst_last;
	logic ap_start;
	logic col_start;
	logic [7:0] reads, writes, chopped;
	logic [15:0] mem [2**MEM_AW];
	logic [MEM_AW-1:0] idx;
	logic [2:0] beat_col;

	// APB slave: answers one cycle into the access phase, registered outputs.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && penable && !pready) begin
				if (!pwrite) begin
					unique case (paddr)
						ADDR_CTRL: prdata <= {31'h0000_0000, enable};
						ADDR_STATUS: prdata <= {24'h00_0000, snap_ref.banks_open};
						ADDR_COUNTS: prdata <= {8'h00, snap_ref.chopped, snap_ref.writes, snap_ref.reads};
						default: pslverr <= 1'b1;
					endcase
				end else if (paddr != ADDR_CTRL && paddr != ADDR_STATUS && paddr != ADDR_COUNTS) begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Decoder enable; a write lands on the answering edge, status is read only.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			enable <= CTRL_ENABLE_RESET;
		end else if (psel && penable && !pready && pwrite && paddr == ADDR_CTRL) begin
			enable <= pwdata[CTRL_ENABLE_BIT];
		end
	end

	// Snapshot handshake, reference side: take the word once the ack has settled, then ask again.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ak1 <= 1'b0;
			ak2 <= 1'b0;
			ak3 <= 1'b0;
			req_tgl <= 1'b0;
			snap_ref <= '0;
		end else begin
			ak1 <= ack_tgl;
			ak2 <= ak1;
			ak3 <= ak2;
			if (ak2 == ak3 && ak2 == req_tgl) begin
				snap_ref <= snap_link;
				req_tgl <= ~req_tgl;
			end
		end
	end

	// Reset and enable enter the command domain through three stages each.
	always_ff @(posedge cmd_clk) begin
		lr1 <= reset;
		lr2 <= lr1;
		lr3 <= lr2;
		if (lr2 == lr3) begin
			link_rst <= lr2;
		end
		en1 <= enable;
		en2 <= en1;
		en3 <= en2;
		if (en2 == en3) begin
			link_en <= en2;
		end
	end

	// Snapshot handshake, command side: the word is frozen until the next request.
	always_ff @(posedge cmd_clk) begin
		if (link_rst) begin
			rq1 <= 1'b0;
			rq2 <= 1'b0;
			rq3 <= 1'b0;
			ack_tgl <= 1'b0;
			snap_link <= '0;
		end else begin
			rq1 <= req_tgl;
			rq2 <= rq1;
			rq3 <= rq2;
			if (rq2 == rq3 && rq3 != ack_tgl) begin
				snap_link <= '{chopped: chopped, writes: writes, reads: reads, banks_open: bank_open};
				ack_tgl <= rq3;
			end
		end
	end

	// Pins are synchronous to the command clock, so one capture stage suffices.
	always_ff @(posedge cmd_clk) begin
		cmd_q <= cmd_pins;
	end

	// Command decode; chip select high or an unknown pattern yields nothing.
	always_comb begin
		kind = CMD_NONE;
		if (link_en && !cmd_q.cs_n) begin
			unique case ({cmd_q.ras_n, cmd_q.cas_n, cmd_q.we_n})
				3'b011: kind = CMD_OPEN;
				3'b010: kind = CMD_CLOSE;
				3'b101: kind = CMD_READ;
				3'b100: kind = CMD_WRITE;
				default: kind = CMD_NONE;
			endcase
		end
	end

	// A column access needs an open bank that is not already closing, and an idle burst engine.
	assign col_start = (kind == CMD_READ || kind == CMD_WRITE) && state == LK_IDLE
		&& bank_open[cmd_q.ba] && close_cnt[cmd_q.ba] == 4'h0;
	assign burst_last = beat == burst_len - 4'h1;
	assign ap_start = state != LK_IDLE && burst_last && burst_ap;

	// Per-bank state: open, row, and the precharge countdown.
	for (genvar i = 0; i < BANKS; i++) begin : g_bank
		always_ff @(posedge cmd_clk) begin
			if (link_rst) begin
				bank_open[i] <= 1'b0;
				close_cnt[i] <= 4'h0;
				open_row[i] <= 14'h0000;
			end else if (close_cnt[i] != 4'h0) begin
				close_cnt[i] <= close_cnt[i] - 4'h1;
				if (close_cnt[i] == 4'h1) begin
					bank_open[i] <= 1'b0;
				end
			end else if (kind == CMD_OPEN && cmd_q.ba == 3'(i) && !bank_open[i]) begin
				bank_open[i] <= 1'b1;
				open_row[i] <= cmd_q.addr;
			end else if (kind == CMD_CLOSE && bank_open[i]
				&& (cmd_q.ba == 3'(i) || cmd_q.addr[AUTO_CLOSE_BIT])) begin
				close_cnt[i] <= PRECHARGE_CK;
			end else if (ap_start && burst_bank == 3'(i)) begin
				close_cnt[i] <= PRECHARGE_CK;
			end
		end
	end

	// Burst engine: one beat per command-clock cycle.
	always_ff @(posedge cmd_clk) begin
		if (link_rst) begin
			state <= LK_IDLE;
			beat <= 4'h0;
			burst_bank <= 3'h0;
			burst_col <= 3'h0;
			burst_len <= BURST_FULL;
			burst_ap <= 1'b0;
		end else begin
			unique case (state)
				LK_IDLE: begin
					beat <= 4'h0;
					if (col_start) begin
						state <= kind == CMD_READ ? LK_READ : LK_WRITE;
						burst_bank <= cmd_q.ba;
						burst_col <= cmd_q.addr[2:0];
						burst_len <= cmd_q.addr[BURST_CHOP_BIT] ? BURST_FULL : BURST_CHOP;
						burst_ap <= cmd_q.addr[AUTO_CLOSE_BIT];
					end
				end
				LK_READ, LK_WRITE: begin
					beat <= beat + 4'h1;
					if (burst_last) begin
						state <= LK_IDLE;
					end
				end
			endcase
		end
	end

	// Activity counters for software, wrapping at 8 bits.
	always_ff @(posedge cmd_clk) begin
		if (link_rst) begin
			reads <= 8'h00;
			writes <= 8'h00;
			chopped <= 8'h00;
		end else if (col_start) begin
			reads <= reads + 8'(kind == CMD_READ);
			writes <= writes + 8'(kind == CMD_WRITE);
			chopped <= chopped + 8'(!cmd_q.addr[BURST_CHOP_BIT]);
		end
	end

	// The burst wraps within an aligned group of eight columns.
	assign beat_col = burst_col + beat[2:0];
	assign idx = {burst_bank, open_row[burst_bank][1:0], beat_col};

	// Write storage: a lane is kept only if unmasked and its strobe pair is driven.
	always_ff @(posedge cmd_clk) begin
		if (state == LK_WRITE) begin
			if (!pad_in.low_lane_write_mask && pad_in.low_lane_strobe != pad_in.low_lane_strobe_n) begin
				mem[idx][7:0] <= pad_in.dq[7:0];
			end
			if (!pad_in.high_lane_write_mask && pad_in.high_lane_strobe != pad_in.high_lane_strobe_n) begin
				mem[idx][15:8] <= pad_in.dq[15:8];
			end
		end
	end

	// Read drive: data and strobe change on the same edge, so they leave edge aligned.
	always_ff @(posedge cmd_clk) begin
		if (link_rst || state != LK_READ) begin
			pad_out <= '{dq: 16'h0000, dq_oe: 1'b0, low_lane_strobe: 1'b0, low_lane_strobe_n: 1'b1,
				high_lane_strobe: 1'b0, high_lane_strobe_n: 1'b1, strobe_oe: 1'b0};
		end else begin
			pad_out.dq <= mem[idx];
			pad_out.dq_oe <= 1'b1;
			pad_out.low_lane_strobe <= !beat[0];
			pad_out.low_lane_strobe_n <= beat[0];
			pad_out.high_lane_strobe <= !beat[0];
			pad_out.high_lane_strobe_n <= beat[0];
			pad_out.strobe_oe <= 1'b1;
		end
	end

	// Checks on the command domain.
	// The decode checks look at the registered pins, one edge after capture.
	cs_gate_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		cmd_q.cs_n |-> kind == CMD_NONE) else $error("command taken with chip select high");
	bad_pattern_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		!cmd_q.cs_n && (cmd_q.ras_n == cmd_q.cas_n) |-> kind == CMD_NONE)
		else $error("illegal pin pattern decoded");
	bank_opens_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		kind == CMD_OPEN && !bank_open[cmd_q.ba] && close_cnt[cmd_q.ba] == 4'h0
		|=> bank_open[$past(cmd_q.ba)] && open_row[$past(cmd_q.ba)] == $past(cmd_q.addr))
		else $error("open command did not open bank");

	// Bank closing: a precharge waits out its count before the bank goes idle.
	close_all_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		kind == CMD_CLOSE && cmd_q.addr[AUTO_CLOSE_BIT] && bank_open[0] && close_cnt[0] == 4'h0
		|-> ##4 bank_open[0] ##1 !bank_open[0]) else $error("all-bank precharge timing wrong");
	auto_close_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		ap_start && bank_open[burst_bank] && close_cnt[burst_bank] == 4'h0
		|=> close_cnt[$past(burst_bank)] == PRECHARGE_CK) else $error("auto close did not start precharge");
	no_closed_col_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		kind == CMD_READ && state == LK_IDLE && !bank_open[cmd_q.ba] |=> state == LK_IDLE)
		else $error("column access on closed bank");
	chop_read_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		col_start && kind == CMD_READ && !cmd_q.addr[BURST_CHOP_BIT]
		|=> (state == LK_READ) [*4] ##1 state == LK_IDLE) else $error("chopped read length wrong");

	// Read drive: data and both strobe pairs leave together.
	read_drive_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		state == LK_READ |=> pad_out.dq_oe && pad_out.strobe_oe && pad_out.dq == $past(mem[idx]))
		else $error("read data not driven");
	strobe_pair_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		pad_out.strobe_oe |-> pad_out.low_lane_strobe != pad_out.low_lane_strobe_n
		&& pad_out.high_lane_strobe != pad_out.high_lane_strobe_n)
		else $error("strobe pair not complementary");

	// Write lanes: a masked lane keeps its old byte, so a broken mask shows up as changed memory.
	mask_hold_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		state == LK_WRITE && pad_in.low_lane_write_mask |=> mem[$past(idx)][7:0] == $past(mem[idx][7:0]))
		else $error("masked lane was stored");
	mask_high_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		state == LK_WRITE && pad_in.high_lane_write_mask |=> mem[$past(idx)][15:8] == $past(mem[idx][15:8]))
		else $error("masked high lane was stored");
	lane_store_a: assert property (@(posedge cmd_clk) disable iff (link_rst)
		state == LK_WRITE && !pad_in.low_lane_write_mask
		&& pad_in.low_lane_strobe != pad_in.low_lane_strobe_n
		|=> mem[$past(idx)][7:0] == $past(pad_in.dq[7:0])) else $error("unmasked low lane not stored");

	// Bus side.
	apb_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
		psel && penable && !pready |=> pready ##1 !pready) else $error("APB answer timing wrong");

	// Main scenarios.
	read_burst_c: cover property (@(posedge cmd_clk) disable iff (link_rst) state == LK_READ && burst_last);
	write_burst_c: cover property (@(posedge cmd_clk) disable iff (link_rst) state == LK_WRITE && burst_last);
	auto_close_c: cover property (@(posedge cmd_clk) disable iff (link_rst) ap_start);
	all_close_c: cover property (@(posedge cmd_clk) disable iff (link_rst)
		kind == CMD_CLOSE && cmd_q.addr[AUTO_CLOSE_BIT]);
	status_read_c: cover property (@(posedge ref_clk) disable iff (reset)
		pready && !pwrite && paddr == ADDR_STATUS && prdata != 32'h0000_0000);

endmodule : d3cpd_decoder

//--- logic/d3cpd_pkg.sv
// Shared constants and types for the DDR3 command-pin decoder.
package d3cpd_pkg;

	// Register byte offsets on the APB slave.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNTS = 8'h08;

	// Control register field and its value after reset.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'b1;

	// Address pin positions with extra meaning.
	localparam int AUTO_CLOSE_BIT = 10;
	localparam int BURST_CHOP_BIT = 12;

	// Counts in command-clock cycles.
	localparam logic [3:0] PRECHARGE_CK = 4'h4;
	localparam logic [3:0] BURST_FULL = 4'h8;
	localparam logic [3:0] BURST_CHOP = 4'h4;

	// Command pins as captured on the command clock.
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [13:0] addr;
	} d3cpd_cmd_t;

	// Decoded command kinds.
	typedef enum logic [2:0] {CMD_NONE, CMD_OPEN, CMD_CLOSE, CMD_READ, CMD_WRITE} d3cpd_kind_t;

	// Data lane pins as seen by the device.
	typedef struct packed {
		logic [15:0] dq;
		logic low_lane_strobe;
		logic low_lane_strobe_n;
		logic high_lane_strobe;
		logic high_lane_strobe_n;
		logic low_lane_write_mask;
		logic high_lane_write_mask;
	} d3cpd_pad_in_t;

	// Data lane drive from the device, with enables.
	typedef struct packed {
		logic [15:0] dq;
		logic dq_oe;
		logic low_lane_strobe;
		logic low_lane_strobe_n;
		logic high_lane_strobe;
		logic high_lane_strobe_n;
		logic strobe_oe;
	} d3cpd_pad_out_t;

	// Status snapshot passed from the command domain.
	typedef struct packed {
		logic [7:0] chopped;
		logic [7:0] writes;
		logic [7:0] reads;
		logic [7:0] banks_open;
	} d3cpd_snap_t;

endpackage : d3cpd_pkg

//--- tb/d3cpd_ctrl_model.sv
// Memory controller model that drives the command pins and the write lanes.
`timescale 1ns/1ps
module d3cpd_ctrl_model (
	input wire logic cmd_clk,
	output d3cpd_pkg::d3cpd_cmd_t cmd_pins,
	output d3cpd_pkg::d3cpd_pad_in_t pad_in,
	input wire d3cpd_pkg::d3cpd_pad_out_t pad_out
);
	import d3cpd_pkg::*;
	d3cpd_pad_in_t drv;

	// The device's drive wins the shared lanes while it enables them.
	always_comb begin
		pad_in = drv;
		if (pad_out.dq_oe)
			pad_in.dq = pad_out.dq;
		if (pad_out.strobe_oe)
			pad_in[5:2] = pad_out[4:1];
	end

	// The bus starts idle, deselected and with no valid strobe pair.
	initial begin
		cmd_pins = '1;
		drv = '0;
	end

	// Beat data for a burst; the bench expects the same pattern.
	function automatic logic [15:0] wd(input logic [15:0] b, input int i);
		return b + 16'(i) * 16'h0101;
	endfunction : wd

	// Pins change just after a rise and are taken at the next one.
	task automatic cmd(input logic [3:0] p, input logic [2:0] ba, input logic [13:0] a);
		@(posedge cmd_clk);
		cmd_pins <= {p, ba, a};
		@(posedge cmd_clk);
		cmd_pins <= {4'hF, ~ba, ~a};
	endtask : cmd

	// Released lanes show inverted data and no differential strobe.
	// The high lane is masked on beat mb and the low lane on the beat after it.
	task automatic wdata(input logic [15:0] b, input int mb, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			@(posedge cmd_clk);
			s = ~i[0];
			drv <= {wd(b, i), {2{s, ~s}}, mb >= 0 && i == mb + 1, i == mb};
		end
		@(posedge cmd_clk);
		drv <= {~drv.dq, 4'hF, 2'b11};
		repeat (2) @(posedge cmd_clk);
	endtask : wdata
endmodule : d3cpd_ctrl_model

//--- tb/ddr3_command_pin_decoder_tb.sv
// Self-checking bench for the DDR3 command-pin decoder.
`timescale 1ns/1ps
module ddr3_command_pin_decoder_tb;
	import d3cpd_pkg::*;
	logic ref_clk = 0;
	logic cmd_clk = 0;
	logic reset, psel, penable, pwrite, pready, pslverr, erv;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	d3cpd_cmd_t cmd_pins;
	d3cpd_pad_in_t pad_in;
	d3cpd_pad_out_t pad_out;
	int bad_count = 0;
	int num_checks = 0;

	// Two unrelated clocks: 100 ns bus clock, 12 ns link clock.
	always #50 ref_clk = ~ref_clk;
	initial #3.7 forever #6 cmd_clk = ~cmd_clk;

	d3cpd_decoder dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_clk(cmd_clk), .cmd_pins(cmd_pins), .pad_in(pad_in), .pad_out(pad_out));
	d3cpd_ctrl_model ctl (.cmd_clk(cmd_clk), .cmd_pins(cmd_pins), .pad_in(pad_in), .pad_out(pad_out));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rdv = prdata;
		erv = pslverr;
		psel <= 0;
		penable <= 0;
		if (n == 40)
			chk("pready", 1, 0);
	endtask : apb

	// The status snapshot lags, so poll a bounded number of times; at least one fresh read is made.
	task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] e);
		rdv = ~e;
		for (int i = 0; i < 30 && rdv !== e; i++)
			apb(0, a, 0);
		chk(nm, e, rdv);
	endtask : poll

	task automatic wr_burst(input logic [2:0] ba, input logic [15:0] b, input int mb);
		ctl.cmd(4'b0100, ba, 14'h1000);
		ctl.wdata(b, mb, 8);
	endtask : wr_burst

	// Reads a burst and checks every beat, its strobes and the length.
	task automatic rd_burst(input logic [13:0] a, input logic [15:0] nb, input logic [15:0] ob, input int n);
		int k;
		logic [15:0] e, o;
		k = 0;
		ctl.cmd(4'b0101, 3'h1, a);
		repeat (16) begin
			@(posedge cmd_clk);
			#1;
			if (pad_out.dq_oe === 1'b1) begin
				e = ctl.wd(nb, k);
				o = ctl.wd(ob, k);
				if (k == 3)
					e[15:8] = o[15:8];
				if (k == 4)
					e[7:0] = o[7:0];
				chk("read beat", e, pad_out.dq);
				chk("strobes", {~k[0], k[0], ~k[0], k[0], 1'b1}, pad_out[4:0]);
				k++;
			end
		end
		chk("beats", n, k);
	endtask : rd_burst

	task automatic s_regs;
		apb(0, ADDR_CTRL, 0);
		chk("ctrl reset", 1, rdv);
		apb(1, ADDR_STATUS, 32'hFF);
		apb(0, ADDR_STATUS, 0);
		chk("status", 0, rdv);
		apb(0, 8'h0C, 0);
		chk("unmapped", 32'h1, {rdv[30:0], erv});
	endtask : s_regs

	task automatic s_cmds;
		ctl.cmd(4'b1011, 3'h2, 14'h0);
		ctl.cmd(4'b0001, 3'h2, 14'h0);
		apb(1, ADDR_CTRL, 0);
		ctl.cmd(4'b0011, 3'h3, 14'h0);
		apb(1, ADDR_CTRL, 1);
		ctl.cmd(4'b0011, 3'h1, 14'h0005);
		poll("one open", ADDR_STATUS, 32'h02);
	endtask : s_cmds

	task automatic s_data;
		wr_burst(3'h1, 16'h1234, -1);
		wr_burst(3'h1, 16'hA050, 3);
		rd_burst(14'h1000, 16'hA050, 16'h1234, 8);
		rd_burst(14'h0000, 16'hA050, 16'h1234, 4);
		poll("counts", ADDR_COUNTS, 32'h00010202);
	endtask : s_data

	task automatic s_close;
		rd_burst(14'h1400, 16'hA050, 16'h1234, 8);
		poll("auto close", ADDR_STATUS, 32'h0);
		rd_burst(14'h1000, 16'hA050, 16'h1234, 0);
		ctl.cmd(4'b0011, 3'h1, 14'h0);
		ctl.cmd(4'b0011, 3'h4, 14'h0);
		poll("two open", ADDR_STATUS, 32'h12);
		ctl.cmd(4'b0010, 3'h4, 14'h0);
		poll("one closed", ADDR_STATUS, 32'h02);
		ctl.cmd(4'b0011, 3'h6, 14'h0);
		ctl.cmd(4'b0011, 3'h0, 14'h0);
		poll("three open", ADDR_STATUS, 32'h43);
		ctl.cmd(4'b0010, 3'h0, 14'h0400);
		poll("all closed", ADDR_STATUS, 32'h0);
	endtask : s_close

	// Main sequence: reset for ten bus cycles, then the scenarios.
	initial begin
		reset = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		repeat (10) @(posedge ref_clk);
		reset <= 0;
		repeat (10) @(posedge cmd_clk);
		s_regs();
		s_cmds();
		s_data();
		s_close();
		end_of_test();
	end

	// Watchdog well beyond the expected run of under a hundred microseconds.
	initial begin
		#1000000;
		bad_count++;
		end_of_test();
	end
endmodule : ddr3_command_pin_decoder_tb
